// [hw/recloser_io.sv]
// recloser_io: request arbitration, shot sequencing and breaker commands
// assumes inputs synchronous to pclk and an apb master on the register bus
//
// Overview of operation
// RULE1 - drive breaker open and close commands
// RULE2 - post time-stamped on/off events, 1 ms resolution
// RULE3 - clearable counters per event kind and request
// RULE4 - object control reports breaker operation failures
// RULE5 - manual open or close resets the sequence; code ignores manual close in general reclaim
// RULE6 - manual close in dead time: reclaim, lockout
// RULE7 - input changes make events, each enableable
// RULE8 - select flag lets enable input switch function
// RULE9 - lockout clear input unlocks the recloser
// RULE10 - lock input locks until lockout clear
// RULE11 - critical request locks at once, no shot
// RULE12 - request one highest, higher overrides lower
// RULE13 - active request with conditions met starts shot
// RULE14 - setting group change takes effect mid-sequence
// RULE15 - starter, shot selector, sorter, shot blocks
// RULE16 - request-active indication while its shot runs
// RULE17 - enabled unless select set and input low
// RULE18 - fault in general reclaim: final trip, lockout
// RULE19 - simultaneous requests: highest one wins
// RULE20 - locked ignores requests, never closes breaker
`timescale 1ns/10ps
module recloser_io
	import recloser_pkg::*;
#(
	parameter int unsigned MS_CYCLES = CYCLES_PER_MS
) (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// control inputs
	input  wire logic [4:0]  reclose_request,
	input  wire logic        recloser_enable_input,
	input  wire logic        lock_input,
	input  wire logic        lockout_clear_input,
	input  wire logic        critical_request_input,
	input  wire logic        setting_group,
	// object control and monitoring
	input  wire logic        breaker_closed,
	input  wire logic        breaker_fail,
	input  wire logic        manual_open,
	input  wire logic        manual_close,
	// commands and indications
	output logic             breaker_open_cmd,
	output logic             breaker_close_cmd,
	output logic [4:0]       request_active_ind,
	output logic             recloser_enabled_ind,
	output logic             recloser_locked_ind,
	// event buffer
	output logic             evt_valid,
	output logic [3:0]       evt_code,
	output logic             evt_on,
	output logic [31:0]      evt_stamp
);
	// ==========================================
	// registers
	logic              sel_reg;            // enable_input_select
	logic [12:0]       evt_en_reg;         // event enables
	logic [15:0]       dead_reg [2];       // dead time per setting group
	logic [15:0]       recl_reg;           // shot reclaim time
	logic [15:0]       grecl_reg;          // general reclaim time
	logic [2:0]        shots_reg;          // shots allowed
	logic [CNT_W-1:0]  cnt_reg [N_CNT];    // cumulative counters
	ar_state_t         state_reg;          // shot selector state
	ar_state_t         state_next;
	logic [2:0]        shot_reg;           // current shot number
	logic [4:0]        owner_reg;          // request owning the sequence
	logic [15:0]       tmr_reg;            // ms timer of current state
	logic [4:0]        req_prev_reg;       // requests last cycle
	logic              man_lock_reg;       // manual close seen in dead time
	logic              clr_pulse;          // counter clear strobe
	event_if           ev ();
	// ==========================================
	// apb decode
	logic        wr_en;
	logic        rd_setup;
	logic [31:0] rd_mux;
	logic        mapped;
	logic [2:0]  cnt_idx;
	assign wr_en    = psel & penable & pready & pwrite;
	assign rd_setup = psel & ~penable;
	assign cnt_idx  = paddr[4:2];
	assign mapped   = (paddr[1:0] == 2'b00) && (paddr <= CNT_BASE + 8'h1c);
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			CTRL_OFS:   rd_mux = {31'h0, sel_reg};
			EVT_EN_OFS: rd_mux = {19'h0, evt_en_reg};
			DEAD0_OFS:  rd_mux = {16'h0, dead_reg[0]};
			DEAD1_OFS:  rd_mux = {16'h0, dead_reg[1]};
			RECL_OFS:   rd_mux = {16'h0, recl_reg};
			GRECL_OFS:  rd_mux = {16'h0, grecl_reg};
			SHOTS_OFS:  rd_mux = {29'h0, shots_reg};
			STATUS_OFS: rd_mux = {21'h0, owner_reg, shot_reg, state_reg};
			default: begin
				if (paddr >= CNT_BASE) begin
					rd_mux = {16'h0, cnt_reg[cnt_idx]};
				end
			end
		endcase
	end
	// answer in the first access cycle, read data captured in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= rd_setup;
			pslverr <= rd_setup & ~mapped;
			if (rd_setup) begin
				prdata <= mapped ? rd_mux : 32'h0000_0000;
			end
		end
	end
	// configuration writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_reg     <= 1'b0;
			clr_pulse   <= 1'b0;
			evt_en_reg  <= EVT_EN_RST;
			dead_reg[0] <= DEAD_RST;
			dead_reg[1] <= DEAD_RST;
			recl_reg    <= RECL_RST;
			grecl_reg   <= RECL_RST;
			shots_reg   <= SHOTS_RST;
		end else begin
			clr_pulse <= wr_en && paddr == CTRL_OFS && pwdata[CTRL_CLR_BIT];
			if (wr_en) begin
				case (paddr)
					CTRL_OFS:   sel_reg     <= pwdata[CTRL_SEL_BIT];
					EVT_EN_OFS: evt_en_reg  <= pwdata[12:0];
					DEAD0_OFS:  dead_reg[0] <= pwdata[15:0];
					DEAD1_OFS:  dead_reg[1] <= pwdata[15:0];
					RECL_OFS:   recl_reg    <= pwdata[15:0];
					GRECL_OFS:  grecl_reg   <= pwdata[15:0];
					SHOTS_OFS:  shots_reg   <= pwdata[2:0];
					default: ;
				endcase
			end
		end
	end
	// ==========================================
	// starter and sorter
	logic       enabled;
	logic [4:0] req_rise;
	logic [4:0] req_win;       // one-hot winner
	logic       req_any;
	logic       fault;         // any request active
	assign enabled  = ~sel_reg | recloser_enable_input;        // RULE8 RULE17
	assign req_rise = reclose_request & ~req_prev_reg;
	assign req_win  = req_rise & (~req_rise + 5'h01);          // RULE12 RULE19
	assign req_any  = |req_rise;
	assign fault    = |reclose_request;
	// shot blocks: timer limit of the running state
	logic [15:0] limit;
	logic        tmr_done;
	logic        more_shots;
	assign limit = (state_reg == ST_DEAD) ? dead_reg[setting_group] :    // RULE14
		(state_reg == ST_RECLAIM) ? recl_reg : grecl_reg;
	assign tmr_done   = tmr_reg >= limit;
	assign more_shots = shot_reg < shots_reg;
	// ==========================================
	// shot selector next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_READY: begin
				if (enabled && req_any) begin
					state_next = ST_START;                               // RULE13
				end
			end
			ST_START: state_next = ST_DEAD;
			ST_DEAD: begin
				if (manual_close) begin
					state_next = ST_GEN_RECLAIM;                         // RULE6
				end else if (tmr_done && !breaker_closed) begin
					state_next = ST_CLOSE;
				end
			end
			ST_CLOSE: begin
				if (breaker_closed) begin
					state_next = ST_RECLAIM;
				end
			end
			ST_RECLAIM: begin
				if (req_any) begin
					state_next = more_shots ? ST_START : ST_FINAL_TRIP;
				end else if (tmr_done) begin
					state_next = ST_GEN_RECLAIM;
				end
			end
			ST_GEN_RECLAIM: begin
				if (req_any || man_lock_reg) begin
					state_next = man_lock_reg ? ST_LOCKED : ST_FINAL_TRIP; // RULE6 RULE18
				end else if (tmr_done) begin
					state_next = ST_READY;
				end
			end
			ST_FINAL_TRIP: state_next = ST_LOCKED;                    // RULE18
			ST_LOCKED: begin
				if (lockout_clear_input && !lock_input && !critical_request_input) begin
					state_next = ST_READY;                               // RULE9 RULE10
				end
			end
			default: state_next = ST_LOCKED;
		endcase
		// overriding conditions, strongest last
		if (state_reg != ST_LOCKED && state_reg != ST_READY && state_reg != ST_DEAD &&
			(manual_open || (manual_close && state_reg != ST_GEN_RECLAIM))) begin
			state_next = ST_READY;                                       // RULE5
		end
		if (state_reg == ST_DEAD && manual_open) begin
			state_next = ST_READY;                                       // RULE5
		end
		if (state_reg != ST_LOCKED && (lock_input || critical_request_input || breaker_fail)) begin
			state_next = ST_LOCKED;                                      // RULE4 RULE10 RULE11
		end
	end
	// ==========================================
	// shot selector state, shot count and owner
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg    <= ST_READY;
			shot_reg     <= 3'h0;
			owner_reg    <= 5'h00;
			tmr_reg      <= 16'h0000;
			req_prev_reg <= 5'h00;
			man_lock_reg <= 1'b0;
		end else begin
			// a manual close in dead time must end in lockout
			if (state_reg == ST_DEAD && state_next == ST_GEN_RECLAIM) begin
				man_lock_reg <= 1'b1;                                     // RULE6
			end else if (state_next == ST_READY || state_next == ST_LOCKED) begin
				man_lock_reg <= 1'b0;
			end
			state_reg    <= state_next;                                   // RULE15
			req_prev_reg <= reclose_request;
			// timer restarts on every state change
			if (state_next != state_reg) begin
				tmr_reg <= 16'h0000;
			end else if (ev.ms_tick && !tmr_done) begin
				tmr_reg <= tmr_reg + 16'h0001;
			end
			if (state_next == ST_START) begin
				shot_reg  <= shot_reg + 3'h1;
				owner_reg <= req_win;                                     // RULE19
			end else if (state_next == ST_READY || state_next == ST_LOCKED) begin
				shot_reg  <= 3'h0;                                        // RULE20
				owner_reg <= 5'h00;
			end
		end
	end
	// ==========================================
	// commands and indications
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			breaker_open_cmd     <= 1'b0;
			breaker_close_cmd    <= 1'b0;
			request_active_ind   <= 5'h00;
			recloser_enabled_ind <= 1'b0;
			recloser_locked_ind  <= 1'b0;
		end else begin
			breaker_open_cmd     <= state_next == ST_START || state_next == ST_FINAL_TRIP; // RULE1
			breaker_close_cmd    <= state_next == ST_CLOSE && !breaker_closed;   // RULE1 RULE20
			request_active_ind   <= (state_next == ST_READY || state_next == ST_LOCKED) ? 5'h00 :
				(state_next == ST_START ? req_win : owner_reg);                    // RULE16
			recloser_enabled_ind <= enabled;                                     // RULE17
			recloser_locked_ind  <= state_next == ST_LOCKED;
		end
	end
	// ==========================================
	// cumulative counters, an increment with a clear in one cycle leaves one
	logic [N_CNT-1:0] cnt_inc;
	assign cnt_inc[4:0]     = (state_next == ST_START && state_reg != ST_START) ? req_win : 5'h00;
	assign cnt_inc[CN_SHOT] = state_next == ST_START && state_reg != ST_START;
	assign cnt_inc[CN_FTRIP] = state_next == ST_FINAL_TRIP && state_reg != ST_FINAL_TRIP;
	assign cnt_inc[CN_LOCK] = state_next == ST_LOCKED && state_reg != ST_LOCKED;
	for (genvar g = 0; g < N_CNT; g++) begin : g_cnt
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_reg[g] <= 16'h0000;
			end else if (cnt_inc[g]) begin
				cnt_reg[g] <= (clr_pulse ? 16'h0000 : cnt_reg[g]) + 16'h0001; // RULE3
			end else if (clr_pulse) begin
				cnt_reg[g] <= 16'h0000;                                   // RULE3
			end
		end
	end
	// ==========================================
	// event sources toward the logger
	assign ev.level  = {recloser_locked_ind, state_reg == ST_FINAL_TRIP, critical_request_input,
		lockout_clear_input, lock_input, recloser_enable_input, reclose_request,
		breaker_close_cmd, breaker_open_cmd};                                // RULE7
	assign ev.enable = evt_en_reg;                                        // RULE7
	event_logger #(
		.MS_CYCLES (MS_CYCLES)
	) u_logger (
		.pclk      (pclk),
		.presetn   (presetn),
		.ev        (ev.logger),
		.evt_valid (evt_valid),
		.evt_code  (evt_code),
		.evt_on    (evt_on),
		.evt_stamp (evt_stamp)
	);
endmodule // recloser_io

// [hw/recloser_pkg.sv]
// recloser_pkg: shared constants of the recloser i/o control block
// assumes a 20 mhz pclk and a 32-bit apb register bus
package recloser_pkg;
	// ==========================================
	// timing
	localparam int unsigned CLK_HZ        = 20_000_000;            // pclk rate
	localparam int unsigned STAMP_RES_MS  = 1;                     // time stamp resolution in ms
	localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000 * STAMP_RES_MS;
	// ==========================================
	// register byte offsets
	localparam logic [7:0] CTRL_OFS    = 8'h00;  // control
	localparam logic [7:0] EVT_EN_OFS  = 8'h04;  // event enable mask
	localparam logic [7:0] DEAD0_OFS   = 8'h08;  // dead time, group 0, ms
	localparam logic [7:0] DEAD1_OFS   = 8'h0c;  // dead time, group 1, ms
	localparam logic [7:0] RECL_OFS    = 8'h10;  // shot reclaim time, ms
	localparam logic [7:0] GRECL_OFS   = 8'h14;  // general reclaim time, ms
	localparam logic [7:0] SHOTS_OFS   = 8'h18;  // number of shots allowed
	localparam logic [7:0] STATUS_OFS  = 8'h1c;  // status, read only
	localparam logic [7:0] CNT_BASE    = 8'h20;  // first counter, read only
	// ==========================================
	// field positions and reset values
	localparam int         CTRL_SEL_BIT = 0;     // enable_input_select
	localparam int         CTRL_CLR_BIT = 1;     // counter clear, self clearing
	localparam int         TIME_W       = 16;    // ms timer width
	localparam int         CNT_W        = 16;    // counter width
	localparam int         N_REQ        = 5;     // reclose requests
	localparam int         N_EVT        = 13;    // event sources
	localparam int         N_CNT        = 8;     // counters
	localparam logic [12:0] EVT_EN_RST  = 13'h1fff;
	localparam logic [15:0] DEAD_RST    = 16'h00c8;  // 200 ms
	localparam logic [15:0] RECL_RST    = 16'h2710;  // 10 s
	localparam logic [2:0]  SHOTS_RST   = 3'h2;
	// event codes, index into the event level vector
	localparam int EV_OPEN = 0;
	localparam int EV_CLOSE = 1;
	localparam int EV_REQ0 = 2;       // 2..6 requests one to five
	localparam int EV_ENABLE = 7;
	localparam int EV_LOCKIN = 8;
	localparam int EV_CLEAR = 9;
	localparam int EV_CRIT = 10;
	localparam int EV_FTRIP = 11;
	localparam int EV_LOCKED = 12;
	// counter slots: 0..4 per request, then shots, final trips, lockouts
	localparam int CN_SHOT = 5;
	localparam int CN_FTRIP = 6;
	localparam int CN_LOCK = 7;
	// shot selector states
	typedef enum logic [2:0] {
		ST_READY, ST_START, ST_DEAD, ST_CLOSE, ST_RECLAIM, ST_GEN_RECLAIM, ST_FINAL_TRIP, ST_LOCKED
	} ar_state_t;
endpackage

// [hw/event_if.sv]
// event_if: event source levels and timebase between control and logger
// assumes one pclk domain
`timescale 1ns/10ps
interface event_if;
	logic [12:0] level;   // current level of each event source
	logic [12:0] enable;  // per-source event enable
	logic        ms_tick; // one pulse per millisecond
	modport src (output level, output enable, input ms_tick);
	modport logger (input level, input enable, output ms_tick);
endinterface

// [hw/event_logger.sv]
// event_logger: ms time stamp and on/off event posting
// assumes the event buffer accepts one record per cycle
`timescale 1ns/10ps
module event_logger
	import recloser_pkg::*;
#(
	parameter int unsigned MS_CYCLES = CYCLES_PER_MS
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// event sources
	event_if.logger          ev,
	// event buffer port
	output logic             evt_valid,
	output logic [3:0]       evt_code,
	output logic             evt_on,
	output logic [31:0]      evt_stamp
);
	// ==========================================
	// millisecond timebase
	logic [15:0] div_reg;       // cycle divider
	logic [31:0] stamp_reg;     // running ms stamp
	logic [12:0] prev_reg;      // last seen levels
	logic [12:0] pend_reg;      // events awaiting posting
	logic [12:0] pick;          // one-hot lowest pending
	logic [3:0]  pick_code;     // its index
	logic        div_end;
	assign div_end = (div_reg == 16'(MS_CYCLES - 1));
	// divider and stamp
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg    <= 16'h0000;
			stamp_reg  <= 32'h0000_0000;
			ev.ms_tick <= 1'b0;
		end else begin
			div_reg    <= div_end ? 16'h0000 : div_reg + 16'h0001;
			stamp_reg  <= div_end ? stamp_reg + 32'h0000_0001 : stamp_reg; // RULE2
			ev.ms_tick <= div_end;
		end
	end
	// ==========================================
	// change detection and posting
	logic [12:0] changed;
	assign changed = (ev.level ^ prev_reg) & ev.enable; // RULE7
	assign pick = pend_reg & (~pend_reg + 13'h0001);
	always_comb begin
		pick_code = 4'h0;
		for (int i = N_EVT - 1; i >= 0; i--) begin
			if (pick[i]) begin
				pick_code = 4'(i);
			end
		end
	end
	// new changes win over the drain of the same bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg  <= 13'h0000;
			pend_reg  <= 13'h0000;
			evt_valid <= 1'b0;
			evt_code  <= 4'h0;
			evt_on    <= 1'b0;
			evt_stamp <= 32'h0000_0000;
		end else begin
			prev_reg  <= ev.level;
			pend_reg  <= (pend_reg & ~pick) | changed;
			evt_valid <= |pend_reg;                            // RULE2
			evt_code  <= pick_code;
			evt_on    <= ev.level[pick_code];
			evt_stamp <= stamp_reg;
		end
	end
endmodule // event_logger

// [bench/breaker_model.sv]
// breaker_model: object control unit and breaker as seen from the recloser
// assumes pclk-synchronous commands and manual controls
`timescale 1ns/10ps
module breaker_model (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// commands and manual control
	input  wire logic open_cmd,
	input  wire logic close_cmd,
	input  wire logic man_open,
	input  wire logic man_close,
	// scenario control: close coil fails
	input  wire logic fail_close,
	// object status back
	output logic      closed,
	output logic      fail
);
	logic [1:0] coil_cnt;  // close travel time
	// opens at once, closes after four cycles of close command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			closed   <= 1'b1;
			fail     <= 1'b0;
			coil_cnt <= 2'h0;
		end else if (open_cmd || man_open) begin
			closed <= 1'b0;
		end else if (man_close) begin
			closed <= 1'b1;
		end else if (close_cmd && !closed) begin
			coil_cnt <= coil_cnt + 2'h1;
			if (coil_cnt == 2'h3) begin
				closed <= !fail_close;
				fail   <= fail_close;
			end
		end else begin
			coil_cnt <= 2'h0;
			fail     <= 1'b0;
		end
	end
endmodule // breaker_model

// [bench/recloser_io_sva.sv]
// recloser_io_sva: port-level assertions for recloser_io
// assumes one pclk domain, bound into every recloser_io
`timescale 1ns/10ps
module recloser_io_sva (
	// apb side
	input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic [31:0] prdata,
	// control inputs and object status
	input wire logic        lock_input, lockout_clear_input, critical_request_input,
	input wire logic        breaker_closed, breaker_fail, manual_open, manual_close,
	// commands, indications, events
	input wire logic        breaker_open_cmd, breaker_close_cmd, recloser_enabled_ind, recloser_locked_ind,
	input wire logic [4:0]  request_active_ind,
	input wire logic        evt_valid,
	input wire logic [3:0]  evt_code
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// apb answer
	ready_one_cycle_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not one cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read gave data");
	// ==========================================
	// breaker commands and lockout
	open_pulse_a: assert property (breaker_open_cmd |=> !breaker_open_cmd)
		else $error("open command too long");
	close_holds_a: assert property (breaker_close_cmd && !breaker_closed && !breaker_fail
		&& !manual_open && !manual_close && !lock_input && !critical_request_input
		&& recloser_enabled_ind |=> breaker_close_cmd) else $error("close dropped early");
	locked_no_close_a: assert property (recloser_locked_ind && $past(recloser_locked_ind)
		|-> !breaker_close_cmd) else $error("close while locked");
	lock_in_a: assert property (lock_input |-> ##[1:2] recloser_locked_ind)
		else $error("lock input did not lock");
	crit_lock_a: assert property ($rose(critical_request_input) |-> ##[1:2] recloser_locked_ind)
		else $error("critical request did not lock");
	clear_unlock_a: assert property (recloser_locked_ind && lockout_clear_input && !lock_input
		&& !critical_request_input && !breaker_fail |-> ##[1:3] !recloser_locked_ind)
		else $error("clear did not unlock");
	one_owner_a: assert property ($onehot0(request_active_ind))
		else $error("two request owners");
	evt_code_a: assert property (evt_valid |-> evt_code <= 4'hc)
		else $error("bad event code");
	// main scenarios
	shot_c: cover property (breaker_open_cmd && request_active_ind != 5'h0);
	lock_c: cover property ($rose(recloser_locked_ind));
	refuse_c: cover property (pready && pslverr);
endmodule // recloser_io_sva

bind recloser_io recloser_io_sva recloser_io_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
	.pslverr, .prdata, .lock_input, .lockout_clear_input, .critical_request_input, .breaker_closed,
	.breaker_fail, .manual_open, .manual_close, .breaker_open_cmd, .breaker_close_cmd,
	.recloser_enabled_ind, .recloser_locked_ind, .request_active_ind, .evt_valid, .evt_code);

// [bench/tb.sv]
// tb: directed apb and pin tests of recloser_io
// assumes the package, design, breaker_model and checker compile first
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("[ERR] %0t got=%h exp=%h", $time, g, e); end end
module tb;
	import recloser_pkg::*;
	// ==========================================
	// signals
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdata, evt_stamp;
	logic [4:0]  reclose_request, request_active_ind;
	logic        recloser_enable_input, lock_input, lockout_clear_input, critical_request_input, setting_group;
	logic        breaker_closed, breaker_fail, manual_open, manual_close, fail_close, evt_valid, evt_on;
	logic        breaker_open_cmd, breaker_close_cmd, recloser_enabled_ind, recloser_locked_ind;
	logic [3:0]  evt_code;
	logic [15:0] seen;                          // event codes posted
	int          fails, samples_checked, opens, o, n;
	recloser_io #(.MS_CYCLES(4)) recloser_io_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .reclose_request, .recloser_enable_input, .lock_input, .lockout_clear_input,
		.critical_request_input, .setting_group, .breaker_closed, .breaker_fail, .manual_open, .manual_close,
		.breaker_open_cmd, .breaker_close_cmd, .request_active_ind, .recloser_enabled_ind,
		.recloser_locked_ind, .evt_valid, .evt_code, .evt_on, .evt_stamp);
	breaker_model breaker_model_inst (.pclk(pclk), .presetn(presetn), .open_cmd(breaker_open_cmd),
		.close_cmd(breaker_close_cmd), .man_open(manual_open), .man_close(manual_close),
		.fail_close(fail_close), .closed(breaker_closed), .fail(breaker_fail));
	// 20 mhz clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// event and open command monitor
	always @(posedge pclk) begin
		if (evt_valid === 1'b1) begin
			seen[evt_code] <= 1'b1;
		end
		if (breaker_open_cmd === 1'b1) begin
			opens <= opens + 1;
		end
	end
	// ==========================================
	// tasks
	task automatic end_of_test();
		$display("counts: checked=%0d mismatches=%0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// one apb transfer; read data and error land in rdata and rerr
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 16) begin
			fails++;
			end_of_test();
		end
	endtask
	// poll the state field, bounded
	task automatic wait_st(input ar_state_t st, input int lim);
		n = 0;
		do begin
			apb(1'b0, STATUS_OFS, 32'h0);
			n++;
		end while (rdata[2:0] !== st && n < lim);
		`CHK(rdata[2:0], st)
		if (rdata[2:0] !== st) end_of_test();
	endtask
	// hold requests and lockout clear for four cycles
	task automatic pins(input logic [4:0] m, input logic c);
		reclose_request <= m;
		lockout_clear_input <= c;
		repeat (4) @(posedge pclk);
		reclose_request <= 5'h0;
		lockout_clear_input <= 1'b0;
		@(posedge pclk);
	endtask
	// ==========================================
	// main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, reclose_request, setting_group} = '0;
		{recloser_enable_input, lock_input, lockout_clear_input, critical_request_input} = '0;
		{manual_open, manual_close, fail_close, seen} = '0;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, EVT_EN_OFS, 32'h0);
		`CHK(rdata, 32'h1fff)
		apb(1'b0, DEAD0_OFS, 32'h0);
		`CHK(rdata, 32'hc8)
		apb(1'b0, SHOTS_OFS, 32'h0);
		`CHK(rdata, 32'h2)
		apb(1'b1, STATUS_OFS, 32'hffffffff);
		wait_st(ST_READY, 1);
		for (int i = 0; i < 2; i++) begin
			apb(1'b0, i ? 8'h44 : 8'h02, 32'h0);
			`CHK({rerr, rdata}, 33'h100000000)
		end
		apb(1'b1, DEAD0_OFS, 32'h2);
		apb(1'b1, DEAD1_OFS, 32'h2);
		apb(1'b1, RECL_OFS, 32'h2);
		apb(1'b1, GRECL_OFS, 32'h14);
		$display("done: registers");
		// two requests at once, then a fault in general reclaim
		pins(5'h14, 1'b0);
		`CHK(request_active_ind, 5'h04)
		`CHK(opens, 1)
		wait_st(ST_GEN_RECLAIM, 60);
		pins(5'h01, 1'b0);
		wait_st(ST_LOCKED, 5);
		apb(1'b0, CNT_BASE + 8'h08, 32'h0);
		`CHK(rdata, 32'h1)
		apb(1'b0, CNT_BASE + 8'h18, 32'h0);
		`CHK(rdata, 32'h1)
		`CHK(seen[EV_REQ0 + 2], 1'b1)
		`CHK(seen[EV_FTRIP], 1'b1)
		pins(5'h00, 1'b1);
		wait_st(ST_READY, 3);
		// group change mid dead time, then manual open in reclaim
		apb(1'b1, DEAD0_OFS, 32'h3c);
		apb(1'b1, RECL_OFS, 32'h3c);
		pins(5'h02, 1'b0);
		setting_group <= 1'b1;
		n = 0;
		while (breaker_close_cmd !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		`CHK(breaker_close_cmd, 1'b1)
		wait_st(ST_RECLAIM, 5);
		manual_open <= 1'b1;
		@(posedge pclk);
		manual_open <= 1'b0;
		wait_st(ST_READY, 3);
		// manual close during dead time
		apb(1'b1, DEAD1_OFS, 32'h3c);
		pins(5'h08, 1'b0);
		wait_st(ST_DEAD, 3);
		manual_close <= 1'b1;
		@(posedge pclk);
		manual_close <= 1'b0;
		wait_st(ST_LOCKED, 8);
		pins(5'h00, 1'b1);
		wait_st(ST_READY, 3);
		$display("done: sequences");
		// lock input with its event masked
		apb(1'b1, EVT_EN_OFS, 32'h1eff);
		seen = '0;
		lock_input <= 1'b1;
		o = opens;
		repeat (3) @(posedge pclk);
		pins(5'h01, 1'b1);
		`CHK(recloser_locked_ind, 1'b1)
		`CHK(opens, o)
		`CHK(seen[EV_LOCKIN], 1'b0)
		`CHK(seen[EV_LOCKED], 1'b1)
		lock_input <= 1'b0;
		pins(5'h00, 1'b1);
		wait_st(ST_READY, 3);
		// critical request together with a request
		critical_request_input <= 1'b1;
		pins(5'h01, 1'b0);
		`CHK(recloser_locked_ind, 1'b1)
		`CHK(opens, o)
		critical_request_input <= 1'b0;
		pins(5'h00, 1'b1);
		wait_st(ST_READY, 3);
		// object control reports a failed close
		apb(1'b1, DEAD1_OFS, 32'h2);
		fail_close <= 1'b1;
		pins(5'h10, 1'b0);
		wait_st(ST_LOCKED, 20);
		fail_close <= 1'b0;
		pins(5'h00, 1'b1);
		wait_st(ST_READY, 3);
		$display("done: lockouts");
		// external enable input in and out of use
		apb(1'b1, CTRL_OFS, 32'h1);
		o = opens;
		pins(5'h01, 1'b0);
		`CHK(recloser_enabled_ind, 1'b0)
		`CHK(opens, o)
		recloser_enable_input <= 1'b1;
		repeat (3) @(posedge pclk);
		`CHK(recloser_enabled_ind, 1'b1)
		apb(1'b1, CTRL_OFS, 32'h0);
		recloser_enable_input <= 1'b0;
		repeat (3) @(posedge pclk);
		`CHK(recloser_enabled_ind, 1'b1)
		// counter clear
		apb(1'b1, CTRL_OFS, 32'h2);
		for (int i = 0; i < N_CNT; i++) begin
			apb(1'b0, CNT_BASE + 8'(4 * i), 32'h0);
			`CHK(rdata, 32'h0)
		end
		$display("done: enable and counters");
		end_of_test();
	end
endmodule // tb
